// ===== hw/odo_operand_org.sv
// operand placement: register merge, control regs, memory operand math
`timescale 1ns/1ps
module odo_operand_org import odo_pkg::*; (
	input wire logic clk_sys,
	input wire logic reset_n,
	// register read request
	input wire logic rd_req,
	input wire odo_rf_t rd_file,
	input wire logic [2:0] rd_sel,
	input wire logic [1:0] rd_ctrl,
	input wire odo_size_t rd_size,
	output logic [31:0] rd_data_q,
	output logic rd_valid_q,
	output logic rd_error_q,
	// register write request
	input wire logic wr_req,
	input wire odo_rf_t wr_file,
	input wire logic [2:0] wr_sel,
	input wire logic [1:0] wr_ctrl,
	input wire odo_size_t wr_size,
	input wire logic [31:0] wr_data,
	output logic wr_error_q,
	// quad result write
	input wire logic quad_req,
	input wire logic [2:0] quad_hi_sel,
	input wire logic [2:0] quad_lo_sel,
	input wire logic [63:0] quad_data,
	// bit-field extract from data register
	input wire logic [31:0] fld_src,
	input wire logic [31:0] fld_offset,
	input wire logic [4:0] fld_width,
	output logic [31:0] fld_data_q,
	// memory operand geometry
	input wire logic [31:0] mem_addr,
	input wire logic [31:0] mem_bit_offset,
	input wire logic [2:0] mem_bit_num,
	output logic [31:0] mem_field_byte_q,
	output logic [2:0] mem_field_bit_q,
	output logic [7:0] mem_bit_mask_q,
	output logic [31:0] block_base_q,
	input wire logic [31:0] be_long,
	output logic [7:0] be_byte0_q,
	output logic [7:0] be_byte3_q,
	// decimal digits
	input wire logic [7:0] bcd_byte,
	output logic [3:0] bcd_unpacked_q,
	output logic [3:0] bcd_packed_hi_q,
	output logic [3:0] bcd_packed_lo_q,
	// floating registers
	input wire logic fp_wr_req,
	input wire logic [2:0] fp_wr_sel,
	input wire logic [79:0] fp_wr_data,
	input wire logic [2:0] fp_rd_sel,
	output logic [79:0] fp_rd_data_q,
	output odo_fclass_t fp_class_q,
	output logic fp_soft_q
);
	////////////////////////////////////////////////////////////////////////
	// control registers
	logic [31:0] status_word_reg_q; // status word, flags in low byte
	logic [31:0] source_space_code_reg_q; // source space code
	logic [31:0] dest_space_code_reg_q; // destination space code
	////////////////////////////////////////////////////////////////////////
	// data and address register banks
	wire logic [31:0] dreg_a; // data read (port a)
	wire logic [31:0] dreg_b; // data read (port b)
	wire logic [31:0] areg_a; // address read
	logic [31:0] dwr_data; // merged data write
	logic dwr_en; // data port a write
	logic awr_en; // address write
	logic [31:0] awr_data; // address write data
	// stage 1 holds pending write, merge against registered read
	logic wr_pend_q;
	odo_rf_t wr_file_q;
	logic [2:0] wr_sel_q;
	logic [1:0] wr_ctrl_q;
	odo_size_t wr_size_q;
	logic [31:0] wr_data_q;
	logic rd_pend_q;
	odo_rf_t rd_file_q;
	logic [1:0] rd_ctrl_q;
	odo_size_t rd_size_q;
	// quad staged one cycle to share timing with merges
	logic quad_pend_q;
	logic [2:0] quad_hi_q;
	logic [2:0] quad_lo_q;
	logic [63:0] quad_data_q;

	// read address: write path reads first when pending
	wire logic [2:0] bank_rd_sel = wr_req ? wr_sel : rd_sel;

	odo_regbank #(.WIDTH(32)) u_dregs (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.rd_a_sel(bank_rd_sel),
		.rd_a_q(dreg_a),
		.rd_b_sel(rd_sel),
		.rd_b_q(dreg_b),
		.wr_a_en(dwr_en),
		.wr_a_sel(quad_pend_q ? quad_hi_q : wr_sel_q),
		.wr_a_data(quad_pend_q ? quad_data_q[63:32] : dwr_data),
		.wr_b_en(quad_pend_q),
		.wr_b_sel(quad_lo_q),
		.wr_b_data(quad_data_q[31:0])
	);

	odo_regbank #(.WIDTH(32)) u_aregs (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.rd_a_sel(rd_sel),
		.rd_a_q(areg_a),
		.rd_b_sel(rd_sel),
		.rd_b_q(),
		.wr_a_en(awr_en),
		.wr_a_sel(wr_sel_q),
		.wr_a_data(awr_data),
		.wr_b_en(1'b0),
		.wr_b_sel(3'h0),
		.wr_b_data(32'h0)
	);

	////////////////////////////////////////////////////////////////////////
	// request staging
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			wr_pend_q <= 1'b0;
			wr_file_q <= ODO_RF_DATA;
			wr_sel_q <= 3'h0;
			wr_ctrl_q <= 2'h0;
			wr_size_q <= ODO_SZ_LONG;
			wr_data_q <= '0;
			rd_pend_q <= 1'b0;
			rd_file_q <= ODO_RF_DATA;
			rd_ctrl_q <= 2'h0;
			rd_size_q <= ODO_SZ_LONG;
			quad_pend_q <= 1'b0;
			quad_hi_q <= 3'h0;
			quad_lo_q <= 3'h0;
			quad_data_q <= '0;
		end else begin
			wr_pend_q <= wr_req & ~quad_req;
			wr_file_q <= wr_file;
			wr_sel_q <= wr_sel;
			wr_ctrl_q <= wr_ctrl;
			wr_size_q <= wr_size;
			wr_data_q <= wr_data;
			rd_pend_q <= rd_req;
			rd_file_q <= rd_file;
			rd_ctrl_q <= rd_ctrl;
			rd_size_q <= rd_size;
			quad_pend_q <= quad_req;
			quad_hi_q <= quad_hi_sel;
			quad_lo_q <= quad_lo_sel;
			quad_data_q <= quad_data;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// data write merge: byte/word keep upper bits
	always_comb begin
		case (wr_size_q)
			ODO_SZ_BYTE: dwr_data = {dreg_a[31:8], wr_data_q[7:0]};
			ODO_SZ_WORD: dwr_data = {dreg_a[31:16], wr_data_q[15:0]};
			ODO_SZ_LONG: dwr_data = wr_data_q;
			default: dwr_data = wr_data_q;
		endcase
	end

	// address write: byte refused, word sign-extended
	wire logic wr_addr = wr_pend_q & (wr_file_q == ODO_RF_ADDR);
	wire logic wr_addr_byte = wr_addr & (wr_size_q == ODO_SZ_BYTE);
	assign awr_en = wr_addr & ~wr_addr_byte;
	assign awr_data = (wr_size_q == ODO_SZ_WORD) ?
		{{16{wr_data_q[15]}}, wr_data_q[15:0]} : wr_data_q;
	assign dwr_en = quad_pend_q | (wr_pend_q & (wr_file_q == ODO_RF_DATA));

	////////////////////////////////////////////////////////////////////////
	// control register writes
	wire logic wr_ctl = wr_pend_q & (wr_file_q == ODO_RF_CTRL);
	wire logic ctl_status = wr_ctl & (wr_ctrl_q == ODO_CR_STATUS);
	wire logic ctl_flags = wr_ctl & (wr_ctrl_q == ODO_CR_FLAGS);
	wire logic ctl_src = wr_ctl & (wr_ctrl_q == ODO_CR_SRC_SPACE);
	wire logic ctl_dst = wr_ctl & (wr_ctrl_q == ODO_CR_DST_SPACE);
	// status and flags take word size only; spaces take long only
	wire logic ctl_word_ok = (wr_size_q == ODO_SZ_WORD);
	wire logic ctl_long_ok = (wr_size_q == ODO_SZ_LONG);
	wire logic ctl_bad = (ctl_status | ctl_flags) & ~ctl_word_ok
		| (ctl_src | ctl_dst) & ~ctl_long_ok;

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			status_word_reg_q <= ODO_STATUS_RESET;
		end else if (ctl_status & ctl_word_ok) begin
			status_word_reg_q <= wr_data_q & ODO_STATUS_MASK;
		end else if (ctl_flags & ctl_word_ok) begin
			// upper byte of flags write is dropped
			status_word_reg_q <= (status_word_reg_q & ~ODO_FLAGS_MASK)
				| (wr_data_q & ODO_FLAGS_MASK);
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			source_space_code_reg_q <= ODO_REG_RESET;
			dest_space_code_reg_q <= ODO_REG_RESET;
		end else begin
			if (ctl_src & ctl_long_ok) begin
				source_space_code_reg_q <= wr_data_q & ODO_SPACE_MASK;
			end
			if (ctl_dst & ctl_long_ok) begin
				dest_space_code_reg_q <= wr_data_q & ODO_SPACE_MASK;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read path
	logic [31:0] ctl_rd; // control read value
	always_comb begin
		case (rd_ctrl_q)
			ODO_CR_STATUS: ctl_rd = status_word_reg_q & ODO_STATUS_MASK;
			ODO_CR_FLAGS: ctl_rd = status_word_reg_q & ODO_FLAGS_MASK;
			ODO_CR_SRC_SPACE: ctl_rd = source_space_code_reg_q;
			ODO_CR_DST_SPACE: ctl_rd = dest_space_code_reg_q;
			default: ctl_rd = '0;
		endcase
	end

	logic [31:0] rd_d; // sized read value
	logic rd_err_d; // refused read
	always_comb begin
		rd_d = '0;
		rd_err_d = 1'b0;
		case (rd_file_q)
			ODO_RF_DATA: begin
				case (rd_size_q)
					ODO_SZ_BYTE: rd_d = {24'h0, dreg_b[7:0]};
					ODO_SZ_WORD: rd_d = {16'h0, dreg_b[15:0]};
					default: rd_d = dreg_b;
				endcase
			end
			ODO_RF_ADDR: begin
				case (rd_size_q)
					ODO_SZ_BYTE: rd_err_d = 1'b1;
					ODO_SZ_WORD: rd_d = {16'h0, areg_a[15:0]};
					default: rd_d = areg_a;
				endcase
			end
			ODO_RF_CTRL: begin
				rd_d = ctl_rd;
				if (rd_ctrl_q == ODO_CR_STATUS || rd_ctrl_q == ODO_CR_FLAGS) begin
					rd_err_d = (rd_size_q != ODO_SZ_WORD);
				end else begin
					rd_err_d = (rd_size_q != ODO_SZ_LONG);
				end
			end
			default: rd_err_d = 1'b1;
		endcase
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			rd_data_q <= '0;
			rd_valid_q <= 1'b0;
			rd_error_q <= 1'b0;
			wr_error_q <= 1'b0;
		end else begin
			rd_data_q <= rd_pend_q & ~rd_err_d ? rd_d : 32'h0;
			rd_valid_q <= rd_pend_q;
			rd_error_q <= rd_pend_q & rd_err_d;
			wr_error_q <= wr_addr_byte | ctl_bad;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// register bit field: offset 0 is msb, wraps in register
	wire logic [4:0] fld_off5 = fld_offset[4:0];
	wire logic [5:0] fld_w = (fld_width == 5'h0) ? 6'd32 : {1'b0, fld_width};
	wire logic [31:0] fld_rot = (fld_src << fld_off5)
		| (fld_src >> (6'd32 - {1'b0, fld_off5}));
	wire logic [31:0] fld_right = fld_rot >> (6'd32 - fld_w);
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			fld_data_q <= '0;
		end else begin
			fld_data_q <= fld_right;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// memory geometry: big-endian bytes, bit and field position
	// signed offset: arithmetic shift gives byte, low bits give msb index
	wire logic [31:0] fld_byte_adj = $signed(mem_bit_offset) >>> 3;
	wire logic [31:0] fld_byte = mem_addr + fld_byte_adj;
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			mem_field_byte_q <= '0;
			mem_field_bit_q <= 3'h0;
			mem_bit_mask_q <= 8'h0;
			block_base_q <= '0;
			be_byte0_q <= 8'h0;
			be_byte3_q <= 8'h0;
		end else begin
			mem_field_byte_q <= fld_byte;
			mem_field_bit_q <= 3'h7 - mem_bit_offset[2:0];
			mem_bit_mask_q <= 8'h01 << mem_bit_num;
			block_base_q <= mem_addr & ODO_BLOCK_MASK;
			be_byte0_q <= be_long[31:24];
			be_byte3_q <= be_long[7:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// decimal digits
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			bcd_unpacked_q <= 4'h0;
			bcd_packed_hi_q <= 4'h0;
			bcd_packed_lo_q <= 4'h0;
		end else begin
			bcd_unpacked_q <= bcd_byte[3:0];
			bcd_packed_hi_q <= bcd_byte[7:4];
			bcd_packed_lo_q <= bcd_byte[3:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// floating data registers, any index usable by any operation
	wire logic [79:0] fp_rd; // registered bank read
	odo_regbank #(.WIDTH(ODO_FP_WIDTH)) u_fregs (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.rd_a_sel(fp_rd_sel),
		.rd_a_q(fp_rd),
		.rd_b_sel(fp_rd_sel),
		.rd_b_q(),
		.wr_a_en(fp_wr_req),
		.wr_a_sel(fp_wr_sel),
		.wr_a_data(fp_wr_data),
		.wr_b_en(1'b0),
		.wr_b_sel(3'h0),
		.wr_b_data(ODO_FP_RESET)
	);
	odo_fclass u_fclass (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.value(fp_rd),
		.class_q(fp_class_q)
	);
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			fp_rd_data_q <= ODO_FP_RESET;
			fp_soft_q <= 1'b0;
		end else begin
			fp_rd_data_q <= fp_rd;
			fp_soft_q <= (fp_class_q == ODO_FC_DENORM)
				| (fp_class_q == ODO_FC_UNSUP);
		end
	end
endmodule : odo_operand_org

// ===== shared/odo_pkg.sv
// constants and types for the operand data organization block
// Operation
// - byte/word writes keep data register upper bits
// - long writes replace whole data register
// - bit zero is least significant bit
// - register field offset zero is msb, wraps
// - quad result into any two data registers
// - unpacked decimal digit in low nibble
// - packed decimal two digits, high nibble first
// - address registers refuse byte operands
// - address source word low half or long
// - address writes full width, word sign-extended
// - reserved control bits read zero
// - status and flags word-size, flags upper zero
// - space code registers keep three low bits
// - memory big-endian, msb at lowest address
// - memory bit seven is byte msb
// - memory field offset zero is base msb
// - field widths 1..32, signed 32-bit offsets
// - block operand 16 bytes, 16-byte aligned
// - eight 80-bit floating data registers
// - hardware float types, others deferred to software
package odo_pkg;
	// operand sizes
	typedef enum logic [1:0] {ODO_SZ_BYTE, ODO_SZ_WORD, ODO_SZ_LONG} odo_size_t;
	// register file selects
	typedef enum logic [1:0] {ODO_RF_DATA, ODO_RF_ADDR, ODO_RF_CTRL} odo_rf_t;
	// control register codes
	localparam logic [1:0] ODO_CR_STATUS = 2'h0;
	localparam logic [1:0] ODO_CR_FLAGS = 2'h1;
	localparam logic [1:0] ODO_CR_SRC_SPACE = 2'h2;
	localparam logic [1:0] ODO_CR_DST_SPACE = 2'h3;
	// implemented bit masks
	localparam logic [31:0] ODO_STATUS_MASK = 32'h0000_f71f;
	localparam logic [31:0] ODO_FLAGS_MASK = 32'h0000_001f;
	localparam logic [31:0] ODO_SPACE_MASK = 32'h0000_0007;
	// reset values
	localparam logic [31:0] ODO_STATUS_RESET = 32'h0000_2700;
	localparam logic [31:0] ODO_REG_RESET = 32'h0000_0000;
	localparam logic [79:0] ODO_FP_RESET = 80'h0;
	// counts
	localparam int ODO_NUM_REGS = 8;
	localparam int ODO_FP_WIDTH = 80;
	localparam int ODO_BLOCK_BYTES = 16;
	localparam logic [31:0] ODO_BLOCK_MASK = 32'hffff_fff0;
	// float type classes
	typedef enum logic [2:0] {ODO_FC_NORM, ODO_FC_ZERO, ODO_FC_INF, ODO_FC_NAN,
		ODO_FC_DENORM, ODO_FC_UNSUP} odo_fclass_t;
endpackage : odo_pkg

// ===== hw/odo_regbank.sv
// eight-entry register memory with registered read data
`timescale 1ns/1ps
module odo_regbank import odo_pkg::*; #(
	parameter int WIDTH = 32
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic [2:0] rd_a_sel,
	output logic [WIDTH-1:0] rd_a_q,
	input wire logic [2:0] rd_b_sel,
	output logic [WIDTH-1:0] rd_b_q,
	input wire logic wr_a_en,
	input wire logic [2:0] wr_a_sel,
	input wire logic [WIDTH-1:0] wr_a_data,
	input wire logic wr_b_en,
	input wire logic [2:0] wr_b_sel,
	input wire logic [WIDTH-1:0] wr_b_data
);
	logic [WIDTH-1:0] mem_q [ODO_NUM_REGS]; // storage
	////////////////////////////////////////////////////////////////////////
	// write ports, port b wins on same entry
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < ODO_NUM_REGS; i++) begin
				mem_q[i] <= '0;
			end
		end else begin
			if (wr_a_en) begin
				mem_q[wr_a_sel] <= wr_a_data;
			end
			if (wr_b_en) begin
				mem_q[wr_b_sel] <= wr_b_data;
			end
		end
	end
	////////////////////////////////////////////////////////////////////////
	// registered read ports
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			rd_a_q <= '0;
			rd_b_q <= '0;
		end else begin
			rd_a_q <= mem_q[rd_a_sel];
			rd_b_q <= mem_q[rd_b_sel];
		end
	end
endmodule : odo_regbank

// ===== hw/odo_fclass.sv
// floating extended value classifier
`timescale 1ns/1ps
module odo_fclass import odo_pkg::*; (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic [79:0] value,
	output odo_fclass_t class_q
);
	wire logic [14:0] expo = value[78:64]; // biased exponent
	wire logic jbit = value[63]; // explicit integer bit
	wire logic frac_nz = |value[62:0]; // fraction nonzero
	wire logic exp_max = &expo; // all ones exponent
	wire logic exp_zero = ~|expo; // zero exponent
	odo_fclass_t class_d;
	////////////////////////////////////////////////////////////////////////
	// class decode; denormal and unnormal go to software
	always_comb begin
		if (exp_max) begin
			class_d = frac_nz ? ODO_FC_NAN : ODO_FC_INF;
		end else if (exp_zero) begin
			class_d = (jbit | frac_nz) ? ODO_FC_DENORM : ODO_FC_ZERO;
		end else begin
			class_d = jbit ? ODO_FC_NORM : ODO_FC_UNSUP;
		end
	end
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			class_q <= ODO_FC_ZERO;
		end else begin
			class_q <= class_d;
		end
	end
endmodule : odo_fclass

// ===== bench/odo_operand_org_monitor.sv
// port-level assertion checker for the operand organization block
`timescale 1ns/1ps
module odo_operand_org_monitor import odo_pkg::*; (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic rd_req,
	input wire odo_rf_t rd_file,
	input wire logic [1:0] rd_ctrl,
	input wire odo_size_t rd_size,
	input wire logic [31:0] rd_data_q,
	input wire logic rd_valid_q,
	input wire logic rd_error_q,
	input wire logic wr_req,
	input wire odo_rf_t wr_file,
	input wire odo_size_t wr_size,
	input wire logic wr_error_q,
	input wire logic quad_req,
	input wire logic [31:0] mem_addr,
	input wire logic [2:0] mem_bit_num,
	input wire logic [7:0] mem_bit_mask_q,
	input wire logic [31:0] block_base_q,
	input wire logic [7:0] bcd_byte,
	input wire logic [3:0] bcd_unpacked_q,
	input wire logic [3:0] bcd_packed_hi_q,
	input wire logic [3:0] bcd_packed_lo_q
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!reset_n);
	////////////////////////////////////////////////////////////
	// read request of one file and size
	sequence s_rd(odo_rf_t f, odo_size_t z);
		rd_req && rd_file == f && rd_size == z;
	endsequence
	// read request of one control register
	sequence s_ctl(logic [1:0] c);
		rd_req && rd_file == ODO_RF_CTRL && rd_ctrl == c;
	endsequence
	////////////////////////////////////////////////////////////
	addr_byte_rd_a:
	assert property (s_rd(ODO_RF_ADDR, ODO_SZ_BYTE) |-> ##2 rd_error_q
		&& rd_data_q == 32'h0) else $error("address byte read accepted");
	data_byte_a:
	assert property (s_rd(ODO_RF_DATA, ODO_SZ_BYTE) |-> ##2 rd_valid_q
		&& rd_data_q[31:8] == 24'h0) else $error("byte read upper bits set");
	addr_word_a:
	assert property (s_rd(ODO_RF_ADDR, ODO_SZ_WORD) |-> ##2 rd_valid_q
		&& rd_data_q[31:16] == 16'h0) else $error("address word read wide");
	space_code_a:
	assert property (s_ctl(ODO_CR_DST_SPACE) |-> ##2 rd_data_q[31:3] == 29'h0)
		else $error("space code upper bits set");
	status_resv_a:
	assert property (s_ctl(ODO_CR_STATUS) |-> ##2
		(rd_data_q & ~ODO_STATUS_MASK) == 32'h0) else $error("status reserved");
	flags_upper_a:
	assert property (s_ctl(ODO_CR_FLAGS) |-> ##2
		(rd_data_q & ~ODO_FLAGS_MASK) == 32'h0) else $error("flags upper set");
	addr_byte_wr_a:
	assert property (wr_req && !quad_req && wr_file == ODO_RF_ADDR && wr_size
		== ODO_SZ_BYTE |-> ##2 wr_error_q) else $error("address byte write ok");
	block_align_a:
	assert property ($past(reset_n) |-> block_base_q ==
		($past(mem_addr) & ODO_BLOCK_MASK)) else $error("block base wrong");
	bit_mask_a:
	assert property ($past(reset_n) |-> mem_bit_mask_q ==
		8'h01 << $past(mem_bit_num)) else $error("bit mask wrong");
	bcd_digits_a:
	assert property ($past(reset_n) |-> {bcd_packed_hi_q, bcd_packed_lo_q}
		== $past(bcd_byte) && {4'h0, bcd_unpacked_q} == ($past(bcd_byte)
		& 8'h0f)) else $error("decimal digits wrong");
endmodule : odo_operand_org_monitor

bind odo_operand_org odo_operand_org_monitor mon (.clk_sys, .reset_n,
	.rd_req, .rd_file, .rd_ctrl, .rd_size, .rd_data_q, .rd_valid_q,
	.rd_error_q, .wr_req, .wr_file, .wr_size, .wr_error_q, .quad_req,
	.mem_addr, .mem_bit_num, .mem_bit_mask_q, .block_base_q, .bcd_byte,
	.bcd_unpacked_q, .bcd_packed_hi_q, .bcd_packed_lo_q);

// ===== bench/odo_exec_model.sv
// execution side model: issues register reads and writes
`timescale 1ns/1ps
module odo_exec_model import odo_pkg::*; (
	input wire logic clk_sys,
	output logic rd_req,
	output odo_rf_t rd_file,
	output logic [2:0] rd_sel,
	output logic [1:0] rd_ctrl,
	output odo_size_t rd_size,
	input wire logic [31:0] rd_data_q,
	input wire logic rd_valid_q,
	input wire logic rd_error_q,
	output logic wr_req,
	output odo_rf_t wr_file,
	output logic [2:0] wr_sel,
	output logic [1:0] wr_ctrl,
	output odo_size_t wr_size,
	output logic [31:0] wr_data,
	input wire logic wr_error_q
);
	// idle request lines from time zero
	initial begin
		{rd_req, rd_sel, rd_ctrl, wr_req, wr_sel, wr_ctrl, wr_data} = '0;
		rd_file = ODO_RF_DATA;
		rd_size = ODO_SZ_BYTE;
		wr_file = ODO_RF_DATA;
		wr_size = ODO_SZ_BYTE;
	end
	// one read pulse; sel also carries the control code
	task automatic do_rd(input odo_rf_t f, input logic [2:0] s,
		input odo_size_t z, output logic [31:0] d, output logic [1:0] ve);
		@(negedge clk_sys);
		rd_req = 1'b1;
		rd_file = f;
		rd_sel = s;
		rd_ctrl = s[1:0];
		rd_size = z;
		@(negedge clk_sys);
		rd_req = 1'b0;
		// answer stands for one cycle, from the first edge after the taking edge
		@(negedge clk_sys);
		ve = {rd_valid_q, rd_error_q};
		d = rd_data_q;
	endtask : do_rd
	// one write pulse, refusal pulse collected
	task automatic do_wr(input odo_rf_t f, input logic [2:0] s,
		input odo_size_t z, input logic [31:0] v, output logic e);
		@(negedge clk_sys);
		wr_req = 1'b1;
		wr_file = f;
		wr_sel = s;
		wr_ctrl = s[1:0];
		wr_size = z;
		wr_data = v;
		@(negedge clk_sys);
		wr_req = 1'b0;
		wr_data = ~v; // released data shows the inverse
		@(negedge clk_sys);
		e = wr_error_q;
	endtask : do_wr
endmodule : odo_exec_model

// ===== bench/odo_operand_org_tb.sv
// self-checking bench for the operand organization block
`timescale 1ns/1ps
module odo_operand_org_tb import odo_pkg::*;;
	localparam odo_rf_t DF = ODO_RF_DATA, AF = ODO_RF_ADDR, CF = ODO_RF_CTRL;
	localparam odo_size_t SB = ODO_SZ_BYTE, SW = ODO_SZ_WORD, SL = ODO_SZ_LONG;
	localparam logic [31:0] F_SRC [4] = '{32'h8000_0001, 32'h8000_0001,
		32'h1234_5678, 32'hc0de_0001};
	localparam logic [31:0] F_OFF [4] = '{32'h0, 32'h1f, 32'h1c, 32'hffff_ffff};
	localparam logic [4:0] F_W [4] = '{5'h1, 5'h2, 5'h8, 5'h0};
	localparam logic [79:0] FP_V [8] = '{80'h3fff_8000_0000_0000_0000,
		80'h8000_0000_0000_0000_0000, 80'h7fff_0000_0000_0000_0000,
		80'hffff_c000_0000_0000_0000, 80'h1, 80'h4001_8000_0000_0000_0001,
		80'hc002_ffff_0000_0000_0000, 80'h3ffe_0000_0000_0000_0003};
	localparam odo_fclass_t FP_C [8] = '{ODO_FC_NORM, ODO_FC_ZERO, ODO_FC_INF,
		ODO_FC_NAN, ODO_FC_DENORM, ODO_FC_NORM, ODO_FC_NORM, ODO_FC_UNSUP};
	logic clk_sys, reset_n, rd_req, rd_valid_q, rd_error_q, wr_req, wr_error_q;
	logic quad_req, fp_wr_req, fp_soft_q;
	odo_rf_t rd_file, wr_file;
	odo_size_t rd_size, wr_size;
	odo_fclass_t fp_class_q;
	logic [1:0] rd_ctrl, wr_ctrl;
	logic [2:0] rd_sel, wr_sel, quad_hi_sel, quad_lo_sel, mem_bit_num;
	logic [2:0] mem_field_bit_q, fp_wr_sel, fp_rd_sel;
	logic [3:0] bcd_unpacked_q, bcd_packed_hi_q, bcd_packed_lo_q;
	logic [4:0] fld_width;
	logic [7:0] mem_bit_mask_q, be_byte0_q, be_byte3_q, bcd_byte;
	logic [31:0] rd_data_q, wr_data, fld_src, fld_offset, fld_data_q, mem_addr;
	logic [31:0] mem_bit_offset, mem_field_byte_q, block_base_q, be_long;
	logic [63:0] quad_data;
	logic [79:0] fp_wr_data, fp_rd_data_q;
	int miscompares = 0, n_compared = 0;
	int cycles = 0;
	////////////////////////////////////////////////////////////
	odo_operand_org dut (.clk_sys, .reset_n, .rd_req, .rd_file, .rd_sel,
		.rd_ctrl, .rd_size, .rd_data_q, .rd_valid_q, .rd_error_q, .wr_req,
		.wr_file, .wr_sel, .wr_ctrl, .wr_size, .wr_data, .wr_error_q,
		.quad_req, .quad_hi_sel, .quad_lo_sel, .quad_data, .fld_src,
		.fld_offset, .fld_width, .fld_data_q, .mem_addr, .mem_bit_offset,
		.mem_bit_num, .mem_field_byte_q, .mem_field_bit_q, .mem_bit_mask_q,
		.block_base_q, .be_long, .be_byte0_q, .be_byte3_q, .bcd_byte,
		.bcd_unpacked_q, .bcd_packed_hi_q, .bcd_packed_lo_q, .fp_wr_req,
		.fp_wr_sel, .fp_wr_data, .fp_rd_sel, .fp_rd_data_q, .fp_class_q,
		.fp_soft_q);
	odo_exec_model ex (.clk_sys, .rd_req, .rd_file, .rd_sel, .rd_ctrl,
		.rd_size, .rd_data_q, .rd_valid_q, .rd_error_q, .wr_req, .wr_file,
		.wr_sel, .wr_ctrl, .wr_size, .wr_data, .wr_error_q);
	////////////////////////////////////////////////////////////
	// 25 MHz clock
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	// hang guard
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			miscompares++;
			conclude();
		end
	end
	// value compare
	task automatic chk(input logic [79:0] got, input logic [79:0] exp);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// flag compare
	task automatic chk_flag(input logic got, input logic exp);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk_flag
	// read and compare data, valid and refusal
	task automatic rd(input odo_rf_t f, input logic [2:0] s,
		input odo_size_t z, input logic [31:0] x, input logic err);
		logic [31:0] d;
		logic [1:0] ve;
		ex.do_rd(f, s, z, d, ve);
		chk(d, x);
		chk_flag(ve[1], 1'b1);
		chk_flag(ve[0], err);
	endtask : rd
	// write and compare refusal
	task automatic wr(input odo_rf_t f, input logic [2:0] s,
		input odo_size_t z, input logic [31:0] v, input logic err);
		logic e;
		ex.do_wr(f, s, z, v, e);
		chk_flag(e, err);
	endtask : wr
	// quad result into two data registers, then read both halves
	task automatic quad(input logic [2:0] h, input logic [2:0] l,
		input logic [63:0] q);
		@(negedge clk_sys);
		{quad_req, quad_hi_sel, quad_lo_sel, quad_data} = {1'b1, h, l, q};
		@(negedge clk_sys);
		quad_req = 1'b0;
		rd(DF, h, SL, q[63:32], 1'b0);
		rd(DF, l, SL, q[31:0], 1'b0);
	endtask : quad
	// register field: offset 0 is msb, wraps, width 0 means 32
	function automatic logic [31:0] fld_exp(logic [31:0] s, logic [4:0] o,
		logic [4:0] w);
		logic [31:0] r;
		r = 32'h0;
		for (int i = 0; i < 32; i++) begin
			if (i < w || w == 5'h0) begin
				r = {r[30:0], s[5'd31 - (o + 5'(i))]};
			end
		end
		return r;
	endfunction : fld_exp
	// verdict
	task automatic conclude;
		$display("compared %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : conclude
	////////////////////////////////////////////////////////////
	// main sequence; control registers use sel as the control code
	initial begin : main
		logic [31:0] eb;
		reset_n = 1'b0;
		{quad_req, quad_hi_sel, quad_lo_sel, quad_data, fld_src} = '0;
		{fld_offset, fld_width, mem_addr, mem_bit_offset, mem_bit_num} = '0;
		{be_long, bcd_byte, fp_wr_req, fp_wr_sel, fp_wr_data, fp_rd_sel} = '0;
		repeat (8) @(negedge clk_sys);
		reset_n = 1'b1;
		rd(CF, 3'h0, SW, ODO_STATUS_RESET, 1'b0);
		rd(CF, 3'h2, SL, 32'h0, 1'b0);
		rd(DF, 3'h3, SL, 32'h0, 1'b0);
		wr(DF, 3'h3, SL, 32'h1234_5678, 1'b0);
		rd(DF, 3'h3, SL, 32'h1234_5678, 1'b0);
		wr(DF, 3'h3, SB, 32'haaaa_aa99, 1'b0);
		rd(DF, 3'h3, SL, 32'h1234_5699, 1'b0);
		wr(DF, 3'h3, SW, 32'hbbbb_8001, 1'b0);
		rd(DF, 3'h3, SL, 32'h1234_8001, 1'b0);
		rd(DF, 3'h3, SB, 32'h01, 1'b0);
		rd(DF, 3'h3, SW, 32'h8001, 1'b0);
		wr(AF, 3'h2, SL, 32'hdead_beef, 1'b0);
		wr(AF, 3'h2, SB, 32'h55, 1'b1);
		rd(AF, 3'h2, SL, 32'hdead_beef, 1'b0);
		rd(AF, 3'h2, SB, 32'h0, 1'b1);
		wr(AF, 3'h2, SW, 32'h0000_8001, 1'b0);
		rd(AF, 3'h2, SL, 32'hffff_8001, 1'b0);
		rd(AF, 3'h2, SW, 32'h8001, 1'b0);
		wr(AF, 3'h5, SW, 32'hffff_7ffe, 1'b0);
		rd(AF, 3'h5, SL, 32'h0000_7ffe, 1'b0);
		wr(CF, 3'h0, SW, 32'h0000_a71f, 1'b0);
		rd(CF, 3'h0, SW, 32'h0000_a71f, 1'b0);
		wr(CF, 3'h1, SW, 32'h0000_ff00, 1'b0);
		rd(CF, 3'h1, SW, 32'h0, 1'b0);
		rd(CF, 3'h0, SW, 32'h0000_a700, 1'b0);
		rd(CF, 3'h1, SL, 32'h0, 1'b1);
		wr(CF, 3'h2, SL, 32'hffff_fffd, 1'b0);
		rd(CF, 3'h2, SL, 32'h5, 1'b0);
		wr(CF, 3'h3, SL, 32'h0000_000a, 1'b0);
		wr(CF, 3'h3, SW, 32'h7, 1'b1);
		rd(CF, 3'h3, SL, 32'h2, 1'b0);
		quad(3'h1, 3'h6, 64'h0123_4567_89ab_cdef);
		quad(3'h0, 3'h7, 64'hfedc_ba98_7654_3210);
		// field, memory geometry and decimal digits
		for (int i = 0; i < 8; i++) begin
			@(negedge clk_sys);
			fld_src = F_SRC[i[1:0]];
			fld_offset = F_OFF[i[1:0]];
			fld_width = F_W[i[1:0]];
			mem_addr = 32'h0000_200c + 32'(i);
			mem_bit_offset = {i[2], 31'(i * 13)} - 32'h8;
			mem_bit_num = i[2:0];
			be_long = 32'ha1b2_c3d4 ^ {4{i[7:0]}};
			bcd_byte = {i[3:0], 4'h9 - i[3:0]};
			eb = mem_addr + {{3{mem_bit_offset[31]}}, mem_bit_offset[31:3]};
			@(negedge clk_sys);
			chk(fld_data_q, fld_exp(fld_src, fld_offset[4:0], fld_width));
			chk(mem_field_byte_q, eb);
			chk(mem_field_bit_q, 3'h7 - mem_bit_offset[2:0]);
			chk(mem_bit_mask_q, 8'h01 << i[2:0]);
			chk(block_base_q, mem_addr & ~32'hf);
			chk({be_byte0_q, be_byte3_q}, {be_long[31:24], be_long[7:0]});
			chk(bcd_unpacked_q, bcd_byte[3:0]);
			chk({bcd_packed_hi_q, bcd_packed_lo_q}, bcd_byte);
		end
		// all eight floating registers, back-to-back writes
		for (int i = 0; i < 8; i++) begin
			@(negedge clk_sys);
			{fp_wr_req, fp_wr_sel, fp_wr_data} = {1'b1, i[2:0], FP_V[i]};
		end
		@(negedge clk_sys);
		fp_wr_req = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			fp_rd_sel = i[2:0];
			repeat (4) @(negedge clk_sys);
			chk(fp_rd_data_q, FP_V[i]);
			chk(fp_class_q, FP_C[i]);
			chk_flag(fp_soft_q, FP_C[i] >= ODO_FC_DENORM);
		end
		conclude();
	end
endmodule : odo_operand_org_tb
